// File: src/psk_pkg.sv
/*
 * Shared constants for the power state and key-mirror controller:
 * register map, field positions, reset values, timing and state codes.
 * Assumes a 100 MHz system clock; all times are turned into cycles here.
 */
package psk_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS      = 10;
  // Key switch filter time, a least time, so it rounds up.
  localparam int unsigned KEY_FILT_NS        = 100000;
  localparam int unsigned KEY_FILT_CYC       =
    (KEY_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PWM_STEPS          = 100;
  localparam int unsigned PWM_SLOW_PERIOD_NS = 10000000;
  localparam int unsigned PWM_FAST_PERIOD_NS = 1000000;
  localparam int unsigned PWM_SLOW_STEP_CYC  =
    PWM_SLOW_PERIOD_NS / PWM_STEPS / CLK_PERIOD_NS;
  localparam int unsigned PWM_FAST_STEP_CYC  =
    PWM_FAST_PERIOD_NS / PWM_STEPS / CLK_PERIOD_NS;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] REG_CTRL1   = 4'h1;
  localparam logic [3:0] REG_KM_CFG  = 4'h6;
  localparam logic [3:0] REG_KM_DUTY = 4'h8;
  localparam logic [3:0] REG_STATUS  = 4'hD;

  localparam int CTRL1_PWR_HOLD  = 7;
  localparam int CTRL1_SELF_TEST = 6;
  localparam logic [7:0] CTRL1_MASK = 8'hD6;
  localparam logic [7:0] CTRL1_RST  = 8'h12;

  localparam int CTRL1_HS_ON = 2;
  localparam int CFG_HSD_BIT = 7;
  localparam logic [7:0] CFG_MASK = 8'h83;
  localparam logic [7:0] CFG_RST  = 8'h00;

  localparam logic [6:0] DUTY_RST = 7'h00;
  localparam logic [6:0] DUTY_MAX = 7'h64;

  localparam int STAT_ANY     = 7;
  localparam int STAT_KEY_LOW = 6;
  localparam int STAT_PWREN   = 5;
  localparam int STAT_PIN     = 4;
  localparam int STAT_FLT_W   = 4;
  localparam logic [7:0] STAT_RST = 8'h40;

  localparam logic [1:0] PWM_NONE = 2'h0;
  localparam logic [1:0] PWM_SLOW = 2'h1;
  localparam logic [1:0] PWM_FAST = 2'h2;

  localparam int SUP_W = 3;
  localparam logic [SUP_W-1:0] SUP_ALL = 3'h7;

  typedef enum logic [2:0] {
    ST_SLEEP  = 3'b001,
    ST_NORMAL = 3'b010,
    ST_PREP   = 3'b100
  } psk_state_e;

endpackage : psk_pkg

// File: src/psk_pwm_if.sv
/*
 * Carrier between the controller and its PWM generator.
 * Assumes both ends share the system clock.
 */
`timescale 1ns/1ns
interface psk_pwm_if;
  logic [1:0] freq_sel;
  logic [6:0] duty;
  logic       pwm_on;

  modport ctrl (output freq_sel, output duty, input pwm_on);
  modport gen  (input freq_sel, input duty, output pwm_on);
endinterface : psk_pwm_if

// File: src/psk_pwm.sv
/*
 * PWM generator for the key-mirror pin in high-side mode.
 * Assumes the system clock; the period is 100 steps of one percent.
 */
`timescale 1ns/1ns
module psk_pwm #(
  parameter int unsigned SLOW_STEP_CYC = psk_pkg::PWM_SLOW_STEP_CYC,
  parameter int unsigned FAST_STEP_CYC = psk_pkg::PWM_FAST_STEP_CYC
) (
  input  wire logic   i_sys_clk,
  input  wire logic   i_rst_b,
  psk_pwm_if.gen      pwm
);

  localparam int unsigned MAXC =
    (SLOW_STEP_CYC > FAST_STEP_CYC) ? SLOW_STEP_CYC : FAST_STEP_CYC;
  localparam int CW = $clog2(MAXC + 1);
  localparam logic [6:0] LAST_STEP = 7'(psk_pkg::PWM_STEPS - 1);

  logic [CW-1:0] pre;
  logic [CW-1:0] step_len;
  logic [6:0]    step;
  logic [6:0]    duty_sat;
  logic [1:0]    sel_q;
  logic          tick;
  logic          restart;
  logic          active;

  assign active   = (pwm.freq_sel == psk_pkg::PWM_SLOW) ||
                    (pwm.freq_sel == psk_pkg::PWM_FAST);
  assign step_len = (pwm.freq_sel == psk_pkg::PWM_SLOW) ?
                    CW'(SLOW_STEP_CYC) : CW'(FAST_STEP_CYC);
  assign tick     = (pre == step_len - 1'b1);
  // A rate change restarts the period so no step runs at a stale length.
  assign restart  = (pwm.freq_sel != sel_q);
  assign duty_sat = (pwm.duty > psk_pkg::DUTY_MAX) ?
                    psk_pkg::DUTY_MAX : pwm.duty;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sel_q <= psk_pkg::PWM_NONE;
    end else begin
      sel_q <= pwm.freq_sel;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pre <= '0;
    end else if (restart || tick || !active) begin
      pre <= '0;
    end else begin
      pre <= pre + 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      step <= '0;
    end else if (restart || !active) begin
      step <= '0;
    end else if (tick) begin
      step <= (step == LAST_STEP) ? 7'h00 : step + 7'h01;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pwm.pwm_on <= 1'b1;
    end else if (!active) begin
      pwm.pwm_on <= 1'b1;
    end else begin
      pwm.pwm_on <= (step < duty_sat);
    end
  end

  chk_pwm_zero_off: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    active && pwm.duty == 7'h00 |=> !pwm.pwm_on)
    else $error("PWM on with zero duty");

  chk_pwm_full_on: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    pwm.duty >= psk_pkg::DUTY_MAX |=> pwm.pwm_on)
    else $error("PWM off with full duty");

endmodule : psk_pwm

// File: src/psk_top.sv
/*
 * Power state machine, power-on defaults, self-test status access and
 * key-mirror pin of an engine-control system controller.
 * Assumes the serial framing sits outside and presents one-cycle
 * register writes; watchdog and fault events arrive on the system clock.
 */
// Notes on behaviour
// - Power-on reset only after filtered key high
// - Key high enables all three supplies
// - Key high means normal state, always
// - Key low, hold low: sleep, all off except open-load detect enable
// - Sleep keeps all outputs off except open-load detect enable
// - Key rising in sleep wakes, issues reset
// - Key low, hold high: prepare to shutdown
// - Only hold bit removes supplies after key
// - Key back high returns normal, keeps registers
// - Power-on reset loads defaults, outputs off
// - Self-test isolates status from fault logic
// - Self-test lets host write ones to status
// - Otherwise host writes only clear status bits
// - Leaving self-test restores status defaults
// - Watchdog reset clears self-test enable bit
// - Mirror pin follows key level
// - Config bit seven picks mirror source
// - Config bits one-zero pick PWM rate
// - Config register resets to zero
// - Duty in one percent steps, saturates
// - Control bit two switches high-side output
// - Hold bit is control bit seven
`timescale 1ns/1ns
module psk_top #(
  parameter int unsigned KEY_FILT_CYC      = psk_pkg::KEY_FILT_CYC,
  parameter int unsigned PWM_SLOW_STEP_CYC = psk_pkg::PWM_SLOW_STEP_CYC,
  parameter int unsigned PWM_FAST_STEP_CYC = psk_pkg::PWM_FAST_STEP_CYC
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_keysw,
  input  wire logic        i_wd_rst,
  input  wire logic [3:0]  i_fault_set,
  input  wire logic        i_relay2_shutdown_dis,
  input  wire logic        i_reg_wr,
  input  wire logic [3:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  output logic      [2:0]  o_state,
  output logic      [2:0]  o_supply_en,
  output logic             o_outputs_en,
  output logic             o_relay2_output_en,
  output logic             o_open_load_det_en,
  output logic             o_por_req,
  output logic             o_key_mirror_out_pin,
  output logic      [7:0]  o_reg_rdata
);

  localparam int FW = $clog2(KEY_FILT_CYC + 1);
  localparam logic [FW-1:0] FILT_LAST = FW'(KEY_FILT_CYC - 1);

  // ****************************************************************
  // Key switch input
  // ****************************************************************
  logic          key_meta;
  logic          key_sync;
  logic          key_filt;
  logic [FW-1:0] filt_cnt;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      key_meta <= 1'b0;
      key_sync <= 1'b0;
    end else begin
      key_meta <= i_keysw;
      key_sync <= key_meta;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      filt_cnt <= '0;
    end else if (key_sync == key_filt || filt_cnt == FILT_LAST) begin
      filt_cnt <= '0;
    end else begin
      filt_cnt <= filt_cnt + 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      key_filt <= 1'b0;
    end else if (key_sync != key_filt && filt_cnt == FILT_LAST) begin
      key_filt <= key_sync;
    end
  end

  // ****************************************************************
  // Power state machine
  // ****************************************************************
  psk_pkg::psk_state_e state;
  psk_pkg::psk_state_e next_state;
  logic [7:0]          ctrl1;
  logic                pwr_hold;
  logic                por_load;

  assign pwr_hold = ctrl1[psk_pkg::CTRL1_PWR_HOLD];

  always_comb begin
    next_state = state;
    unique case (state)
      psk_pkg::ST_SLEEP: begin
        if (key_filt) begin
          next_state = psk_pkg::ST_NORMAL;
        end
      end
      psk_pkg::ST_NORMAL: begin
        if (!key_filt) begin
          next_state = pwr_hold ? psk_pkg::ST_PREP : psk_pkg::ST_SLEEP;
        end
      end
      psk_pkg::ST_PREP: begin
        if (key_filt) begin
          next_state = psk_pkg::ST_NORMAL;
        end else if (!pwr_hold) begin
          next_state = psk_pkg::ST_SLEEP;
        end
      end
      default: begin
        next_state = psk_pkg::ST_SLEEP;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= psk_pkg::ST_SLEEP;
    end else begin
      state <= next_state;
    end
  end

  assign por_load = (state == psk_pkg::ST_SLEEP) &&
                    (next_state == psk_pkg::ST_NORMAL);
  assign o_state  = state;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0]                    km_cfg;
  logic [6:0]                    km_duty;
  logic [7:0]                    stat;
  logic [7:0]                    next_ctrl1;
  logic [psk_pkg::STAT_FLT_W-1:0] next_flt;
  logic                          self_test;
  logic                          self_test_enable_exit;
  logic                          wr_ctrl;
  logic                          wr_stat;
  psk_pwm_if                     pwm_bus ();

  assign wr_ctrl   = i_reg_wr && (i_reg_addr == psk_pkg::REG_CTRL1);
  assign wr_stat   = i_reg_wr && (i_reg_addr == psk_pkg::REG_STATUS);
  assign self_test = ctrl1[psk_pkg::CTRL1_SELF_TEST];

  always_comb begin
    next_ctrl1 = ctrl1;
    if (por_load) begin
      next_ctrl1 = psk_pkg::CTRL1_RST;
    end else begin
      if (wr_ctrl) begin
        next_ctrl1 = i_reg_wdata & psk_pkg::CTRL1_MASK;
      end
      if (i_wd_rst) begin
        next_ctrl1[psk_pkg::CTRL1_SELF_TEST] = 1'b0;
      end
    end
  end

  assign self_test_enable_exit = self_test && !next_ctrl1[psk_pkg::CTRL1_SELF_TEST];

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl1 <= psk_pkg::CTRL1_RST;
    end else begin
      ctrl1 <= next_ctrl1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      km_cfg  <= psk_pkg::CFG_RST;
      km_duty <= psk_pkg::DUTY_RST;
    end else if (por_load) begin
      km_cfg  <= psk_pkg::CFG_RST;
      km_duty <= psk_pkg::DUTY_RST;
    end else if (i_reg_wr) begin
      if (i_reg_addr == psk_pkg::REG_KM_CFG) begin
        km_cfg <= i_reg_wdata & psk_pkg::CFG_MASK;
      end
      if (i_reg_addr == psk_pkg::REG_KM_DUTY) begin
        km_duty <= i_reg_wdata[6:0];
      end
    end
  end

  // write-zero clear, a fault in the same cycle wins.
  always_comb begin
    next_flt = stat[psk_pkg::STAT_FLT_W-1:0];
    if (wr_stat) begin
      next_flt = next_flt & i_reg_wdata[psk_pkg::STAT_FLT_W-1:0];
    end
    next_flt = next_flt | i_fault_set;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stat <= psk_pkg::STAT_RST;
    end else if (por_load || self_test_enable_exit) begin
      stat <= psk_pkg::STAT_RST;
    end else if (self_test) begin
      if (wr_stat) begin
        stat <= i_reg_wdata;
      end
    end else begin
      stat[psk_pkg::STAT_FLT_W-1:0] <= next_flt;
      stat[psk_pkg::STAT_ANY]       <= |next_flt;
      stat[psk_pkg::STAT_KEY_LOW]   <= !key_filt;
      stat[psk_pkg::STAT_PWREN]     <= pwr_hold;
      stat[psk_pkg::STAT_PIN]       <= o_key_mirror_out_pin;
    end
  end

  // Unmapped addresses read as zero; data follows the address one edge on.
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_rdata <= '0;
    end else begin
      case (i_reg_addr)
        psk_pkg::REG_CTRL1:   o_reg_rdata <= ctrl1;
        psk_pkg::REG_KM_CFG:  o_reg_rdata <= km_cfg;
        psk_pkg::REG_KM_DUTY: o_reg_rdata <= {1'b0, km_duty};
        psk_pkg::REG_STATUS:  o_reg_rdata <= stat;
        default:              o_reg_rdata <= '0;
      endcase
    end
  end

  // ****************************************************************
  // Supplies, outputs and key-mirror pin
  // ****************************************************************
  assign pwm_bus.freq_sel = km_cfg[1:0];
  assign pwm_bus.duty     = km_duty;

  psk_pwm #(
    .SLOW_STEP_CYC (PWM_SLOW_STEP_CYC),
    .FAST_STEP_CYC (PWM_FAST_STEP_CYC)
  ) u_pwm (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .pwm       (pwm_bus)
  );

  // Outputs are built from the next state so they line up with o_state.
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_supply_en        <= '0;
      o_outputs_en       <= 1'b0;
      o_relay2_output_en <= 1'b0;
      o_por_req          <= 1'b0;
    end else begin
      o_supply_en  <= (next_state == psk_pkg::ST_SLEEP) ?
                      '0 : psk_pkg::SUP_ALL;
      o_outputs_en <= (next_state == psk_pkg::ST_NORMAL);
      o_relay2_output_en <= (next_state == psk_pkg::ST_NORMAL) ||
        ((next_state == psk_pkg::ST_PREP) && i_relay2_shutdown_dis);
      o_por_req    <= por_load;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_open_load_det_en <= 1'b1;
    end else if (por_load) begin
      o_open_load_det_en <= 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_key_mirror_out_pin <= 1'b0;
    end else if (next_state != psk_pkg::ST_NORMAL) begin
      o_key_mirror_out_pin <= 1'b0;
    end else if (!km_cfg[psk_pkg::CFG_HSD_BIT] || por_load) begin
      o_key_mirror_out_pin <= key_filt;
    end else begin
      o_key_mirror_out_pin <= ctrl1[psk_pkg::CTRL1_HS_ON] &&
                              pwm_bus.pwm_on;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_filter_length: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    $changed(key_filt) |-> $past(filt_cnt) == FILT_LAST)
    else $error("Key level passed filter early");

  chk_key_to_normal: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    key_filt |=> state == psk_pkg::ST_NORMAL)
    else $error("Key high without normal state");

  chk_sleep_entry: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    !key_filt && !pwr_hold && state != psk_pkg::ST_SLEEP
    |=> state == psk_pkg::ST_SLEEP)
    else $error("Sleep not entered");

  chk_sleep_all_off: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    state == psk_pkg::ST_SLEEP |-> o_supply_en == '0 &&
      !o_outputs_en && !o_relay2_output_en && !o_key_mirror_out_pin)
    else $error("Output active in sleep");

  chk_prep_entry: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    state == psk_pkg::ST_NORMAL && !key_filt && pwr_hold
    |=> state == psk_pkg::ST_PREP && o_supply_en == psk_pkg::SUP_ALL
      && !o_key_mirror_out_pin)
    else $error("Prepare to shutdown not entered");

  chk_wake_por: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    state == psk_pkg::ST_SLEEP ##1 state == psk_pkg::ST_NORMAL
    |-> o_por_req ##1 !o_por_req)
    else $error("Wake without reset pulse");

  chk_stat_no_set: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    !self_test && i_fault_set == '0 |=>
      (stat[3:0] & ~$past(stat[3:0])) == '0)
    else $error("Status bit set without fault");

  chk_self_test_enable_write: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    self_test && wr_stat && !i_wd_rst && !por_load
    |=> stat == $past(i_reg_wdata))
    else $error("Self-test write not stored");

  chk_self_test_enable_restore: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    $fell(self_test) |-> stat == psk_pkg::STAT_RST)
    else $error("Status not restored after test");

  chk_wd_clear: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    i_wd_rst |=> !self_test)
    else $error("Watchdog left self-test set");

  chk_mirror_follow: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    state == psk_pkg::ST_NORMAL && !km_cfg[psk_pkg::CFG_HSD_BIT]
    |=> o_key_mirror_out_pin == $past(key_filt))
    else $error("Mirror pin does not follow key");

endmodule : psk_top

// File: tb/psk_host_model.sv
/*
 * Host-side model of the register port: one-cycle write strobes and
 * read-back of the addressed register.
 * Assumes the block samples address and data on the rising clock edge
 * and shows read data one edge after the address.
 */
`timescale 1ns/1ns
module psk_host_model (
  input  wire logic       i_sys_clk,
  input  wire logic [7:0] i_reg_rdata,
  output logic            o_reg_wr,
  output logic      [3:0] o_reg_addr,
  output logic      [7:0] o_reg_wdata
);
  // ****************************************************************
  // Register access
  // ****************************************************************
  initial begin
    o_reg_wr    = 1'b0;
    o_reg_addr  = 4'h0;
    o_reg_wdata = 8'h00;
  end

  // Released data is inverted so that a late sample cannot pass.
  // host write strobe
  task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    #1;
    o_reg_wr    = 1'b1;
    o_reg_addr  = a;
    o_reg_wdata = d;
    @(posedge i_sys_clk);
    #1;
    o_reg_wr    = 1'b0;
    o_reg_wdata = ~d;
  endtask : write_reg

  task automatic read_reg(input logic [3:0] a, input logic [7:0] m,
                          output logic [7:0] d);
    @(posedge i_sys_clk);
    #1;
    o_reg_addr = a;
    repeat (2) @(posedge i_sys_clk);
    #1;
    d = i_reg_rdata & m;
  endtask : read_reg
endmodule : psk_host_model

// File: tb/tb_top.sv
/*
 * Self-checking testbench for the power state and key-mirror block.
 * Assumes shortened filter and PWM step counts set at the instance.
 */
`timescale 1ns/1ns
module tb_top;
  logic        i_sys_clk;
  logic        i_rst_b;
  logic        keysw;
  logic        wd_rst;
  logic        r2_dis;
  logic [3:0]  fault;
  logic        reg_wr;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic [2:0]  state;
  logic [2:0]  supply;
  logic        outs_en;
  logic        relay2_en;
  logic        ol_en;
  logic        por;
  logic        pin;
  logic [7:0]  rd;
  int          error_cnt;
  int          cmp_count;

  // ****************************************************************
  // Instances and clock
  // ****************************************************************
  psk_top #(.KEY_FILT_CYC(4), .PWM_SLOW_STEP_CYC(5),
    .PWM_FAST_STEP_CYC(3)) psk_top_i (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_keysw(keysw),
    .i_wd_rst(wd_rst), .i_fault_set(fault),
    .i_relay2_shutdown_dis(r2_dis), .i_reg_wr(reg_wr),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_state(state),
    .o_supply_en(supply), .o_outputs_en(outs_en),
    .o_relay2_output_en(relay2_en), .o_open_load_det_en(ol_en),
    .o_por_req(por), .o_key_mirror_out_pin(pin),
    .o_reg_rdata(reg_rdata));

  psk_host_model psk_host_model_i (
    .i_sys_clk(i_sys_clk), .i_reg_rdata(reg_rdata), .o_reg_wr(reg_wr),
    .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata));

  always #5 i_sys_clk = ~i_sys_clk;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic summarize();
    $display("errors %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    psk_host_model_i.write_reg(a, d);
  endtask : wr

  task automatic rdc(input string nm, input logic [3:0] a,
                     input logic [7:0] m, input logic [7:0] e);
    psk_host_model_i.read_reg(a, m, rd);
    check(nm, 16'(rd), 16'(e));
  endtask : rdc

  // The state is polled each cycle so a one-cycle pulse is not missed.
  task automatic wait_state(input logic [2:0] exp);
    for (int n = 0; n < 50; n++) begin
      cyc(1);
      if (state === exp) return;
    end
    error_cnt++;
    $display("wrong value state expected %h seen %h", exp, state);
    summarize();
  endtask : wait_state

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    logic [3:0] ad [5];
    logic [7:0] ex [5];
    ad = '{psk_pkg::REG_CTRL1, psk_pkg::REG_KM_CFG, psk_pkg::REG_KM_DUTY,
           psk_pkg::REG_STATUS, 4'h3};
    ex = '{8'h12, 8'h00, 8'h00, 8'h40, 8'h00};
    check("supplies", 16'(supply), 16'h0000);
    check("outputs", 16'(outs_en), 16'h0000);
    check("open load", 16'(ol_en), 16'h0001);
    for (int i = 0; i < 5; i++) begin
      rdc("reset value", ad[i], 8'hFF, ex[i]);
    end
  endtask : t_reset

  task automatic t_wake();
    keysw = 1'b1;
    cyc(2);
    keysw = 1'b0;
    cyc(20);
    check("short key", 16'(state), 16'(psk_pkg::ST_SLEEP));
    keysw = 1'b1;
    wait_state(psk_pkg::ST_NORMAL);
    check("por", 16'(por), 16'h0001);
    check("supplies", 16'(supply), 16'h0007);
    check("outputs", 16'(outs_en), 16'h0001);
    check("pin", 16'(pin), 16'h0001);
    cyc(1);
    check("por end", 16'(por), 16'h0000);
  endtask : t_wake

  task automatic t_prep();
    r2_dis = 1'b1;
    wr(psk_pkg::REG_CTRL1, 8'h92);
    cyc(4);
    check("hold normal", 16'(state), 16'(psk_pkg::ST_NORMAL));
    keysw = 1'b0;
    wait_state(psk_pkg::ST_PREP);
    check("prep supplies", 16'(supply), 16'h0007);
    check("prep outputs", 16'(outs_en), 16'h0000);
    check("relay2 kept", 16'(relay2_en), 16'h0001);
    check("prep pin", 16'(pin), 16'h0000);
    r2_dis = 1'b0;
    cyc(3);
    check("relay2 off", 16'(relay2_en), 16'h0000);
    keysw = 1'b1;
    wait_state(psk_pkg::ST_NORMAL);
    check("no por", 16'(por), 16'h0000);
    rdc("ctrl kept", psk_pkg::REG_CTRL1, 8'hFF, 8'h92);
    rdc("live status", psk_pkg::REG_STATUS, 8'h70, 8'h30);
    keysw = 1'b0;
    wait_state(psk_pkg::ST_PREP);
    wr(psk_pkg::REG_CTRL1, 8'h12);
    wait_state(psk_pkg::ST_SLEEP);
    check("sleep supplies", 16'(supply), 16'h0000);
    check("sleep relay2", 16'(relay2_en), 16'h0000);
    check("sleep pin", 16'(pin), 16'h0000);
  endtask : t_prep

  task automatic t_fault(input logic [3:0] f);
    fault = f;
    cyc(1);
    fault = 4'h0;
  endtask : t_fault

  task automatic t_selftest();
    wr(psk_pkg::REG_CTRL1, 8'h52);
    wr(psk_pkg::REG_STATUS, 8'h00);
    t_fault(4'h1);
    rdc("isolated", psk_pkg::REG_STATUS, 8'hFF, 8'h00);
    wr(psk_pkg::REG_STATUS, 8'hFF);
    rdc("test ones", psk_pkg::REG_STATUS, 8'hFF, 8'hFF);
    wr(psk_pkg::REG_CTRL1, 8'h12);
    rdc("defaults", psk_pkg::REG_STATUS, 8'h8F, 8'h00);
    t_fault(4'h5);
    rdc("fault set", psk_pkg::REG_STATUS, 8'h8F, 8'h85);
    wr(psk_pkg::REG_STATUS, 8'hFE);
    rdc("clear one", psk_pkg::REG_STATUS, 8'h8F, 8'h84);
    wr(psk_pkg::REG_STATUS, 8'hFF);
    rdc("no set", psk_pkg::REG_STATUS, 8'h8F, 8'h84);
  endtask : t_selftest

  task automatic t_watchdog();
    wr(psk_pkg::REG_CTRL1, 8'h52);
    wd_rst = 1'b1;
    cyc(1);
    wd_rst = 1'b0;
    rdc("wd clears", psk_pkg::REG_CTRL1, 8'hFF, 8'h12);
  endtask : t_watchdog

  task automatic t_mirror();
    logic [7:0]  cfg [5];
    logic [7:0]  dut [5];
    logic [15:0] cnt;
    logic [15:0] stp;
    logic [15:0] exp;
    cfg = '{8'h81, 8'h82, 8'h81, 8'h80, 8'h82};
    dut = '{8'h32, 8'h32, 8'h7F, 8'h0A, 8'h00};
    wr(psk_pkg::REG_KM_CFG, 8'hFF);
    rdc("cfg mask", psk_pkg::REG_KM_CFG, 8'hFF, 8'h83);
    wr(psk_pkg::REG_KM_DUTY, 8'hFF);
    rdc("duty mask", psk_pkg::REG_KM_DUTY, 8'hFF, 8'h7F);
    wr(psk_pkg::REG_KM_CFG, 8'h80);
    cyc(6);
    check("hs off", 16'(pin), 16'h0000);
    wr(psk_pkg::REG_CTRL1, 8'h16);
    cyc(6);
    check("hs on", 16'(pin), 16'h0001);
    for (int i = 0; i < 5; i++) begin
      wr(psk_pkg::REG_KM_CFG, cfg[i]);
      wr(psk_pkg::REG_KM_DUTY, dut[i]);
      cyc(20);
      stp = (cfg[i][1:0] == 2'h1) ? 16'h0005 : 16'h0003;
      exp = (dut[i] > 8'h64) ? 16'h0064 : 16'(dut[i]);
      exp = (cfg[i][1:0] == 2'h0) ? 16'h0064 * stp : exp * stp;
      cnt = 16'h0000;
      repeat (100 * stp) begin
        cyc(1);
        if (pin === 1'b1) cnt++;
      end
      check("pwm high", cnt, exp);
    end
    wr(psk_pkg::REG_KM_CFG, 8'h00);
    cyc(6);
    check("follow key", 16'(pin), 16'h0001);
  endtask : t_mirror

  initial begin
    i_sys_clk = 1'b0;
    i_rst_b   = 1'b0;
    keysw     = 1'b0;
    wd_rst    = 1'b0;
    r2_dis    = 1'b0;
    fault     = 4'h0;
    error_cnt = 0;
    cmp_count = 0;
    cyc(2);
    i_rst_b = 1'b1;
    t_reset();
    t_wake();
    t_prep();
    t_wake();
    t_selftest();
    t_watchdog();
    t_mirror();
    summarize();
  end
endmodule : tb_top
